// [rtl/board_parallel_port_control.sv]
`timescale 1ns/1ps
module board_parallel_port_control (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Host I/O access
    input wire bppc_pkg::bppc_req_s hostReq,
    output logic [7:0] hostRdata,
    output logic hostRvalid,
    // Bidirectional data port pins
    input wire logic [7:0] bidirIn,
    output logic [7:0] bidirOut,
    output logic bidirOe_n,
    // Input-only port pins
    input wire logic [7:0] inputPort,
    // Board events
    input wire bppc_pkg::bppc_evt_s evt,
    // Dual-port arbitration
    input wire logic backplaneDpReq,
    input wire logic localBackplaneStart,
    output logic dpLocked,
    output logic dpGrantBackplane,
    // Board control outputs
    output logic [7:0] ctlPort,
    output logic controlPortDriven,
    output logic printer_strobe_n,
    output logic nmiToCpu,
    output logic bus_timeout_irq,
    output logic led_timeout,
    output logic user_latch_irq,
    output logic led_user,
    output logic backplane_irq1_n,
    output logic backplane_irq2_n,
    output logic printer_irq,
    output logic led_printer
);
    bppc_pkg::bppc_dir_e dirMode;
    logic [7:0] ctl;
    logic [7:0] bidirLatch;
    logic toutPrev;
    logic wrCtl;
    logic wrCfg;
    logic wrBidir;
    logic rdBidir;
    logic rdInput;
    logic [2:0] bsrSel;
    logic [7:0] next_rdata;
    logic next_rvalid;

    assign wrCtl = hostReq.wr && (hostReq.addr == bppc_pkg::ADDR_CTL);
    assign wrCfg = hostReq.wr && (hostReq.addr == bppc_pkg::ADDR_CFG);
    assign wrBidir = hostReq.wr && (hostReq.addr == bppc_pkg::ADDR_BIDIR);
    assign rdBidir = hostReq.rd && (hostReq.addr == bppc_pkg::ADDR_BIDIR);
    assign rdInput = hostReq.rd && (hostReq.addr == bppc_pkg::ADDR_INPUT);
    assign bsrSel = hostReq.wdata[bppc_pkg::BSR_SEL_MSB:bppc_pkg::BSR_SEL_LSB];

    // Configuration: only the two basic-mode words are honoured; others leave mode alone
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dirMode <= bppc_pkg::BPPC_DIR_ALL_IN;
        end else if (wrCfg && hostReq.wdata[bppc_pkg::CFG_MODESET_BIT]) begin
            if (hostReq.wdata == bppc_pkg::CFG_BIDIR_OUT) begin
                dirMode <= bppc_pkg::BPPC_DIR_A_OUT;
            end else if (hostReq.wdata == bppc_pkg::CFG_BIDIR_IN) begin
                dirMode <= bppc_pkg::BPPC_DIR_A_IN;
            end
            // Strobed and bidirectional handshake modes are not implemented.
        end
    end

    // Control port: full byte writes and single-bit set/reset. A write of either supported
    // layout word clears the outputs, as the port hardware does on reprogramming.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctl <= bppc_pkg::CTL_RESET;
        end else if (wrCtl) begin
            ctl <= hostReq.wdata;
        end else if (wrCfg && !hostReq.wdata[bppc_pkg::CFG_MODESET_BIT]) begin
            ctl[bsrSel] <= hostReq.wdata[bppc_pkg::BSR_VAL_BIT];
        end else if (wrCfg && ((hostReq.wdata == bppc_pkg::CFG_BIDIR_OUT) ||
                               (hostReq.wdata == bppc_pkg::CFG_BIDIR_IN))) begin
            ctl <= bppc_pkg::CTL_RESET;
        end
    end

    // Output latch of the data port keeps its byte while the port is input
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bidirLatch <= bppc_pkg::BYTE_ZERO;
        end else if (wrBidir) begin
            bidirLatch <= hostReq.wdata;
        end
    end

    // Read data: registered, one cycle after the request
    always_comb begin
        next_rdata = bppc_pkg::BYTE_ZERO;
        next_rvalid = 1'b0;
        if (rdBidir) begin
            next_rdata = (dirMode == bppc_pkg::BPPC_DIR_A_OUT) ? bidirLatch : bidirIn;
            next_rvalid = 1'b1;
        end else if (rdInput) begin
            next_rdata = inputPort;
            next_rvalid = 1'b1;
        end else if (hostReq.rd) begin
            next_rvalid = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hostRdata <= bppc_pkg::BYTE_ZERO;
            hostRvalid <= 1'b0;
        end else begin
            hostRdata <= next_rdata;
            hostRvalid <= next_rvalid;
        end
    end

    // Rising edge detector on the time-out input
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            toutPrev <= 1'b0;
        end else begin
            toutPrev <= evt.busTimeout;
        end
    end

    // Three set/clear latches share one module
    bppc_latch uToutLatch (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .setIn(evt.busTimeout && !toutPrev),
        .clearN(ctl[bppc_pkg::CTL_TOUT_EN]),
        .q(bus_timeout_irq)
    );

    bppc_latch uUserLatch (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .setIn(evt.userLatchSet),
        .clearN(ctl[bppc_pkg::CTL_USER_CLR]),
        .q(user_latch_irq)
    );

    bppc_latch uPrnLatch (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .setIn(!evt.printerAckN),
        .clearN(ctl[bppc_pkg::CTL_PRN_CLR]),
        .q(printer_irq)
    );

    // Pin outputs follow the held control byte, layout mode, data latch, time-out latch, event and arbitration inputs directly
    assign ctlPort = ctl;
    assign controlPortDriven = (dirMode != bppc_pkg::BPPC_DIR_ALL_IN);
    assign bidirOut = bidirLatch;
    assign bidirOe_n = (dirMode != bppc_pkg::BPPC_DIR_A_OUT);
    assign printer_strobe_n = !ctl[bppc_pkg::CTL_STROBE];
    assign dpLocked = !ctl[bppc_pkg::CTL_LOCK];
    // Deadlock escape: backplane wins when both sides start together
    assign dpGrantBackplane = backplaneDpReq && (!dpLocked || localBackplaneStart);
    assign nmiToCpu = evt.nonmaskableRequest && !ctl[bppc_pkg::CTL_NMIMASK];
    assign led_timeout = bus_timeout_irq;
    assign led_user = ctl[bppc_pkg::CTL_USER_CLR];
    assign backplane_irq1_n = !ctl[bppc_pkg::CTL_BPIRQ1];
    assign backplane_irq2_n = !ctl[bppc_pkg::CTL_BPIRQ2];
    assign led_printer = ctl[bppc_pkg::CTL_PRN_CLR];

    // Register writes
    a_ctl_write_loads: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrCtl |=> ctlPort == $past(hostReq.wdata))
        else $error("control write not applied");

    a_strobe_inv: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrCtl |=> printer_strobe_n == !$past(hostReq.wdata[bppc_pkg::CTL_STROBE]))
        else $error("strobe polarity wrong");

    a_strobe_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!wrCtl && !wrCfg) |=> $stable(printer_strobe_n))
        else $error("strobe changed without write");

    a_bpirq_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!wrCtl && !wrCfg) |=> $stable(backplane_irq1_n) && $stable(backplane_irq2_n))
        else $error("backplane interrupt changed without write");

    a_bsr_one_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wrCfg && !hostReq.wdata[bppc_pkg::CFG_MODESET_BIT])
        |=> ctlPort[$past(bsrSel)] == $past(hostReq.wdata[bppc_pkg::BSR_VAL_BIT]))
        else $error("bit set/reset failed");

    a_bsr_others: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wrCfg && !hostReq.wdata[bppc_pkg::CFG_MODESET_BIT]) |=> $onehot0(ctlPort ^ $past(ctlPort)))
        else $error("bit set/reset disturbed other bits");

    a_modeset_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wrCfg && ((hostReq.wdata == bppc_pkg::CFG_BIDIR_OUT) || (hostReq.wdata == bppc_pkg::CFG_BIDIR_IN)))
        |=> ctlPort == bppc_pkg::CTL_RESET)
        else $error("mode word did not clear control port");

    a_cfg_dir_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wrCfg && hostReq.wdata == bppc_pkg::CFG_BIDIR_OUT) |=> !bidirOe_n && controlPortDriven)
        else $error("output layout word did not drive port");

    a_cfg_dir_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wrCfg && hostReq.wdata == bppc_pkg::CFG_BIDIR_IN) |=> bidirOe_n && controlPortDriven)
        else $error("input layout word did not release port");

    a_cfg_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wrCfg && hostReq.wdata[bppc_pkg::CFG_MODESET_BIT] && (hostReq.wdata != bppc_pkg::CFG_BIDIR_OUT)
            && (hostReq.wdata != bppc_pkg::CFG_BIDIR_IN)) |=> $stable(dirMode))
        else $error("unsupported mode word applied");

    a_cfg_stable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wrCfg |=> $stable(bidirOe_n) && $stable(controlPortDriven))
        else $error("port layout changed without mode word");

    a_bidir_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wrBidir |=> bidirOut == $past(hostReq.wdata))
        else $error("data port write not latched");

    // Reset state; checked while reset is low, so no disable here
    a_reset_ports: assert property (@(posedge clk_sys)
        !rst_n |=> bidirOe_n && !controlPortDriven && !hostRvalid)
        else $error("reset left a port driven");

    a_reset_lock: assert property (@(posedge clk_sys)
        !rst_n |=> dpLocked && printer_strobe_n)
        else $error("reset left dual-port memory unlocked");

    a_reset_irq: assert property (@(posedge clk_sys)
        !rst_n |=> !ctlPort[bppc_pkg::CTL_NMIMASK] && !bus_timeout_irq && !led_timeout)
        else $error("reset interrupt state wrong");

    // Host reads
    a_input_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rdInput |=> hostRvalid && hostRdata == $past(inputPort))
        else $error("input port read wrong");

    a_bidir_read_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rdBidir && !bidirOe_n) |=> hostRvalid && hostRdata == $past(bidirOut))
        else $error("data port read in output layout wrong");

    a_bidir_read_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rdBidir && bidirOe_n) |=> hostRvalid && hostRdata == $past(bidirIn))
        else $error("data port read in input layout wrong");

    a_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
        hostReq.rd |=> hostRvalid)
        else $error("read not answered");

    a_no_stray_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !hostReq.rd |=> !hostRvalid)
        else $error("answer without read");

    // Board control functions
    a_nmi_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctlPort[bppc_pkg::CTL_NMIMASK] |-> !nmiToCpu)
        else $error("masked request leaked");

    a_nmi_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!ctlPort[bppc_pkg::CTL_NMIMASK] && evt.nonmaskableRequest) |-> nmiToCpu)
        else $error("unmasked request lost");

    a_dp_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        dpLocked != ctlPort[bppc_pkg::CTL_LOCK])
        else $error("lock polarity wrong");

    a_dp_escape: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (backplaneDpReq && localBackplaneStart) |-> dpGrantBackplane)
        else $error("deadlock escape missing");

    a_dp_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (dpLocked && !localBackplaneStart) |-> !dpGrantBackplane)
        else $error("grant given through lock");

    a_dp_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!dpLocked && backplaneDpReq) |-> dpGrantBackplane)
        else $error("grant refused while unlocked");

    a_tout_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctlPort[bppc_pkg::CTL_TOUT_EN] |=> !bus_timeout_irq && !led_timeout)
        else $error("timeout latch not held clear");

    a_tout_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctlPort[bppc_pkg::CTL_TOUT_EN] && $rose(evt.busTimeout)) |=> bus_timeout_irq && led_timeout)
        else $error("timeout edge not latched");

    a_tout_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctlPort[bppc_pkg::CTL_TOUT_EN] && !$rose(evt.busTimeout)) |=> $stable(bus_timeout_irq))
        else $error("timeout latch changed without edge");

    a_user_led: assert property (@(posedge clk_sys) disable iff (!rst_n)
        led_user == ctlPort[bppc_pkg::CTL_USER_CLR])
        else $error("user LED wrong");

    a_user_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctlPort[bppc_pkg::CTL_USER_CLR] |=> !user_latch_irq)
        else $error("user latch not cleared");

    a_user_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctlPort[bppc_pkg::CTL_USER_CLR] && evt.userLatchSet) |=> user_latch_irq)
        else $error("user latch not set");

    a_bpirq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (backplane_irq1_n != ctlPort[bppc_pkg::CTL_BPIRQ1]) && (backplane_irq2_n != ctlPort[bppc_pkg::CTL_BPIRQ2]))
        else $error("backplane interrupt polarity wrong");

    a_prn_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctlPort[bppc_pkg::CTL_PRN_CLR] |=> !printer_irq)
        else $error("printer latch not cleared");

    a_prn_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctlPort[bppc_pkg::CTL_PRN_CLR] && !evt.printerAckN) |=> printer_irq)
        else $error("printer latch not set");

    a_prn_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctlPort[bppc_pkg::CTL_PRN_CLR] && evt.printerAckN) |=> $stable(printer_irq))
        else $error("printer latch changed without acknowledge");

    a_prn_led: assert property (@(posedge clk_sys) disable iff (!rst_n)
        led_printer == ctlPort[bppc_pkg::CTL_PRN_CLR])
        else $error("printer LED wrong");

    c_bsr_write: cover property (@(posedge clk_sys) wrCfg && !hostReq.wdata[bppc_pkg::CFG_MODESET_BIT]);
    c_tout_set: cover property (@(posedge clk_sys) $rose(bus_timeout_irq));
    c_prn_set: cover property (@(posedge clk_sys) $rose(printer_irq));
    c_dir_out: cover property (@(posedge clk_sys) !bidirOe_n && rdBidir);
endmodule // board_parallel_port_control

// [rtl/bppc_pkg.sv]
package bppc_pkg;
    // I/O locations of the four byte registers
    localparam logic [7:0] ADDR_BIDIR = 8'hc8;
    localparam logic [7:0] ADDR_INPUT = 8'hca;
    localparam logic [7:0] ADDR_CTL = 8'hcc;
    localparam logic [7:0] ADDR_CFG = 8'hce;

    // Configuration words for the two supported layouts
    localparam logic [7:0] CFG_BIDIR_OUT = 8'h82;
    localparam logic [7:0] CFG_BIDIR_IN = 8'h92;

    // Configuration byte fields
    localparam int CFG_MODESET_BIT = 7;
    localparam int BSR_SEL_LSB = 1;
    localparam int BSR_SEL_MSB = 3;
    localparam int BSR_VAL_BIT = 0;

    // Control port bit positions
    localparam int CTL_STROBE = 0;
    localparam int CTL_LOCK = 1;
    localparam int CTL_NMIMASK = 2;
    localparam int CTL_TOUT_EN = 3;
    localparam int CTL_USER_CLR = 4;
    localparam int CTL_BPIRQ1 = 5;
    localparam int CTL_BPIRQ2 = 6;
    localparam int CTL_PRN_CLR = 7;

    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        BPPC_DIR_ALL_IN,
        BPPC_DIR_A_OUT,
        BPPC_DIR_A_IN
    } bppc_dir_e;

    // Host I/O request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bppc_req_s;

    // Board-side event inputs
    typedef struct packed {
        logic busTimeout;
        logic userLatchSet;
        logic printerAckN;
        logic nonmaskableRequest;
    } bppc_evt_s;
endpackage

// [rtl/bppc_latch.sv]
`timescale 1ns/1ps
module bppc_latch (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Latch controls
    input wire logic setIn,
    input wire logic clearN,
    // State
    output logic q
);
    // Clocked set/clear latch; clear wins so the forbidden input state stays defined
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= 1'b0;
        end else if (!clearN) begin
            q <= 1'b0;
        end else if (setIn) begin
            q <= 1'b1;
        end
    end

    a_latch_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !clearN |=> !q)
        else $error("latch not cleared");
    a_latch_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (clearN && setIn) |=> q)
        else $error("latch not set");
endmodule // bppc_latch

// [tb/bppc_host_model.sv]
`timescale 1ns/1ps
module bppc_host_model (
    // Clock
    input wire logic clk_sys,
    // Request to the port
    output bppc_pkg::bppc_req_s hostReq
);
    initial hostReq = '0;
    // One byte access, then an idle cycle so no request is raised in the step that drops one
    task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d);
        hostReq = {rd, ~rd, a, d};
        @(negedge clk_sys);
        hostReq = '0;
        @(negedge clk_sys);
    endtask
    // Bring-up: layout word first, then mask, lock release and time-out enable
    task automatic init(input logic [7:0] cfg);
        access(1'b0, bppc_pkg::ADDR_CFG, cfg);
        access(1'b0, bppc_pkg::ADDR_CTL, 8'h0e);
    endtask
endmodule // bppc_host_model

// [tb/tb_board_parallel_port_control.sv]
`timescale 1ns/1ps
module tb_board_parallel_port_control;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] bidirIn = 8'h00;
    logic [7:0] inputPort = 8'h00;
    bppc_pkg::bppc_evt_s evt = 4'b0011;
    logic backplaneDpReq = 1'b0;
    logic localBackplaneStart = 1'b0;
    bppc_pkg::bppc_req_s hostReq;
    logic [7:0] hostRdata, bidirOut, ctlPort, v, got;
    logic hostRvalid, bidirOe_n, dpLocked, dpGrantBackplane, controlPortDriven, printer_strobe_n, nmiToCpu;
    logic bus_timeout_irq, led_timeout, user_latch_irq, led_user;
    logic backplane_irq1_n, backplane_irq2_n, printer_irq, led_printer;
    logic [7:0] expQ[$];
    logic [31:0] rng = 32'd56510;
    int n_mismatch = 0;
    int n_compared = 0;

    board_parallel_port_control dut (.clk_sys, .rst_n, .hostReq, .hostRdata, .hostRvalid, .bidirIn, .bidirOut,
        .bidirOe_n, .inputPort, .evt, .backplaneDpReq, .localBackplaneStart, .dpLocked, .dpGrantBackplane,
        .ctlPort, .controlPortDriven, .printer_strobe_n, .nmiToCpu, .bus_timeout_irq, .led_timeout,
        .user_latch_irq, .led_user, .backplane_irq1_n, .backplane_irq2_n, .printer_irq, .led_printer);
    bppc_host_model host (.clk_sys, .hostReq);

    initial forever #2.5 clk_sys = ~clk_sys;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wc(input logic [7:0] d);
        host.access(1'b0, bppc_pkg::ADDR_CTL, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        host.access(1'b1, a, 8'h00);
    endtask

    // Read answers are matched in order of issue; a stray answer meets an unknown and fails
    always @(negedge clk_sys) begin
        if (hostRvalid === 1'b1) begin
            got = (expQ.size() > 0) ? expQ.pop_front() : 8'hxx;
            check(hostRdata, got);
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        check(ctlPort, 8'h00);
        check({bidirOe_n, controlPortDriven, dpLocked, printer_strobe_n, backplane_irq1_n, backplane_irq2_n,
            nmiToCpu}, 7'h5f);
        evt.busTimeout = 1'b1;
        repeat (3) @(negedge clk_sys);
        check({bus_timeout_irq, led_timeout}, 2'b00);
        evt.busTimeout = 1'b0;
        host.access(1'b0, bppc_pkg::ADDR_CFG, 8'h80);
        check({bidirOe_n, controlPortDriven}, 2'b10);
        host.init(bppc_pkg::CFG_BIDIR_OUT);
        check({bidirOe_n, controlPortDriven, ctlPort}, {2'b01, 8'h0e});
        check({nmiToCpu, dpLocked}, 2'b00);
        for (int i = 0; i < 24; i++) begin
            rng = xs(rng);
            v = rng[7:0];
            {backplaneDpReq, localBackplaneStart, evt.nonmaskableRequest} = rng[10:8];
            wc(v);
            check(ctlPort, v);
            check({printer_strobe_n, dpLocked, nmiToCpu, led_user, backplane_irq1_n, backplane_irq2_n, led_printer},
                {~v[0], ~v[1], rng[8] & ~v[2], v[4], ~v[5], ~v[6], v[7]});
            check(dpGrantBackplane, rng[10] & (v[1] | rng[9]));
        end
        v = 8'h00;
        wc(v);
        for (int i = 0; i < 16; i++) begin
            host.access(1'b0, bppc_pkg::ADDR_CFG, i[7:0]);
            v[i[3:1]] = i[0];
            check(ctlPort, v);
        end
        // Sources held active while the clears are low: clear must win
        {evt.busTimeout, evt.userLatchSet, evt.printerAckN} = 3'b110;
        wc(8'h00);
        repeat (2) @(negedge clk_sys);
        check({bus_timeout_irq, user_latch_irq, printer_irq}, 3'b000);
        wc(8'h98);
        repeat (2) @(negedge clk_sys);
        check({bus_timeout_irq, user_latch_irq, printer_irq}, 3'b011);
        evt.busTimeout = 1'b0;
        repeat (2) @(negedge clk_sys);
        {evt.busTimeout, evt.userLatchSet, evt.printerAckN} = 3'b101;
        repeat (3) @(negedge clk_sys);
        check({bus_timeout_irq, led_timeout, user_latch_irq, printer_irq}, 4'hf);
        host.access(1'b0, bppc_pkg::ADDR_CFG, 8'h0e);
        repeat (2) @(negedge clk_sys);
        check({printer_irq, led_printer, user_latch_irq}, 3'b001);
        rng = xs(rng);
        inputPort = rng[7:0];
        rd(bppc_pkg::ADDR_INPUT, inputPort);
        host.access(1'b0, bppc_pkg::ADDR_BIDIR, rng[15:8]);
        check(bidirOut, rng[15:8]);
        rd(bppc_pkg::ADDR_BIDIR, rng[15:8]);
        host.init(bppc_pkg::CFG_BIDIR_IN);
        check({bidirOe_n, controlPortDriven}, 2'b11);
        // A write to the input-only port must change nothing
        host.access(1'b0, bppc_pkg::ADDR_INPUT, 8'hff);
        check({bidirOut, ctlPort}, {rng[15:8], 8'h0e});
        bidirIn = rng[23:16];
        rd(bppc_pkg::ADDR_BIDIR, bidirIn);
        rd(bppc_pkg::ADDR_CTL, 8'h00);
        for (int i = 0; i < 10 && expQ.size() > 0; i++) @(negedge clk_sys);
        if (expQ.size() > 0) n_mismatch++;
        stop_test();
    end
endmodule // tb_board_parallel_port_control
